/* File: mrs_consts.svh */
// Purpose: constants of the rtu slave framer
// Assumes: 50 MHz hclk, byte-wide fields in 32-bit words
// Notes: included by the framer and its crc unit
//
// Function
// - bit rate selectable 300 to 38400 bps, same at both ends
// - characters are eleven bits: one start bit, eight raw data bits, parity or second stop, stop
// - framing: no parity two stops, odd one stop, even one stop
// - station 0 to 247, up to 32 slaves per line
// - frames bounded by at least 3.5 character times of silence
// - frame is address, function, data bytes, crc low then high
// - normal answer echoes address and function unchanged
// - error answer sets function bit 7 and carries an error code
// - bad function, register address or data gets an error answer
// - receive, framing or crc errors get no answer at all
// - address 0 is broadcast: execute, never answer
// - broadcast executes whatever the station number is
// - monitor, command, volatile frequency requests answered within 12 ms
// - parameter access 30 ms, clear 5 s, reset command unanswered
// - holding registers span numbers 40001 to 49999
// - only binary rtu framing, ascii framing is dropped
// - accept functions 03, 06, 08, 10, 46 hex, others get error
// - only 06 and 10 hex run as broadcast
`ifndef MRS_CONSTS_SVH
`define MRS_CONSTS_SVH

`define MRS_CLK_HZ 50000000
`define MRS_US_PER_S 1000000
`define MRS_T_FAST_US 12000
`define MRS_T_SLOW_US 30000
`define MRS_T_CLR_US 5000000

`define MRS_OFS_CTRL 8'h00
`define MRS_OFS_STAT 8'h04
`define MRS_OFS_CMD 8'h08
`define MRS_OFS_ERRC 8'h0c
`define MRS_WIN_RXB 2'h1
`define MRS_WIN_TXB 2'h2
`define MRS_CTRL_RST 16'h1500

`define MRS_BPS0 32'h0000012c
`define MRS_BPS1 32'h00000258
`define MRS_BPS2 32'h000004b0
`define MRS_BPS3 32'h00000960
`define MRS_BPS4 32'h000012c0
`define MRS_BPS5 32'h00002580
`define MRS_BPS6 32'h00004b00
`define MRS_BPS7 32'h00009600

`define MRS_CHAR_BITS 4'hb
`define MRS_SIL_HALFBITS 7'h4d
`define MRS_MIN_LEN 8'h04
`define MRS_STATION_MAX 8'hf7
`define MRS_ADDR_BCAST 8'h00

`define MRS_FC_RD 8'h03
`define MRS_FC_WR1 8'h06
`define MRS_FC_DIAG 8'h08
`define MRS_FC_WRN 8'h10
`define MRS_FC_LOG 8'h46
`define MRS_EXC_BIT 8'h80
`define MRS_EXC_FUNC 8'h01
`define MRS_EXC_ADDR 8'h02
`define MRS_REG_MAX 16'h270e

`define MRS_CRC_POLY 16'ha001
`define MRS_CRC_INIT 16'hffff

`endif

/* File: mrs_pkg.sv */
// Purpose: types of the rtu slave framer
// Assumes: nothing beyond the constants header
// Notes: register words are cast onto these structs
package mrs_pkg;

  typedef enum logic [1:0] {
    PS_NONE_2STOP,
    PS_ODD_1STOP,
    PS_EVEN_1STOP,
    PS_RSVD
  } mrs_par_e;

  typedef struct packed {
    logic protocol_select_setting;
    logic [1:0] answer_class;
    mrs_par_e parity_stop_setting;
    logic [2:0] bit_rate_setting;
    logic [7:0] station_number_setting;
  } mrs_ctrl_s;

  typedef struct packed {
    logic [7:0] exc_code;
    logic [7:0] resp_len;
    logic [4:0] pad;
    logic drop;
    logic exc;
    logic send;
  } mrs_cmd_s;

  typedef struct packed {
    logic [7:0] rx_len;
    logic [3:0] pad;
    logic late;
    logic bcast;
    logic tx_busy;
    logic pending;
  } mrs_stat_s;

  typedef enum logic {RX_IDLE, RX_BITS} mrs_rx_e;
  typedef enum logic {TX_IDLE, TX_BITS} mrs_tx_e;

endpackage : mrs_pkg

/* File: mrs_crc16.sv */
// Purpose: byte-serial frame check accumulator
// Assumes: one byte per enabled clock
// Notes: init and en together seed and then take the byte
`timescale 1ns/1ps
`include "mrs_consts.svh"
module mrs_crc16 (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  import mrs_pkg::*;

  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  always_comb begin
    crc_nxt = init ? `MRS_CRC_INIT : crc_r;
    if (en) begin
      crc_nxt = crc_nxt ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
        crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ `MRS_CRC_POLY) : (crc_nxt >> 1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_r <= `MRS_CRC_INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;

endmodule : mrs_crc16

/* File: mrs_framer.sv */
// Purpose: rtu slave framing on a half-duplex line, registers on ahb-lite
// Assumes: line_in synchronous to hclk, idle high
// Notes: software executes delivered requests and writes answer data
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "mrs_consts.svh"
module mrs_framer #(
  parameter int CLK_HZ = `MRS_CLK_HZ,
  parameter int RXB_DEPTH = 16,
  parameter int TXB_DEPTH = 16,
  parameter int FAST_CYC = CLK_HZ / `MRS_US_PER_S * `MRS_T_FAST_US,
  parameter int SLOW_CYC = CLK_HZ / `MRS_US_PER_S * `MRS_T_SLOW_US,
  parameter int CLR_CYC = CLK_HZ / `MRS_US_PER_S * `MRS_T_CLR_US
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe
);
  import mrs_pkg::*;

  localparam int CW = 20;
  localparam int SW = CW + 7;

  if (RXB_DEPTH < 8 || RXB_DEPTH > 16 || TXB_DEPTH < 2 || TXB_DEPTH > 16 ||
      CLK_HZ / 300 >= (1 << CW) || CLK_HZ / 38400 < 4) begin : g_chk
    $error("mrs_framer: unsupported parameter values");
  end

  function automatic logic [CW-1:0] f_div(input logic [2:0] s);
    int b;
    case (s)
      3'h0: b = `MRS_BPS0;
      3'h1: b = `MRS_BPS1;
      3'h2: b = `MRS_BPS2;
      3'h3: b = `MRS_BPS3;
      3'h4: b = `MRS_BPS4;
      3'h5: b = `MRS_BPS5;
      3'h6: b = `MRS_BPS6;
      default: b = `MRS_BPS7;
    endcase
    f_div = CW'(CLK_HZ / b);
  endfunction : f_div

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait, registered read data
  logic ap_wr_r, ap_wr_nxt;
  logic [7:0] ap_addr_r, ap_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  mrs_ctrl_s ctrl_r, ctrl_nxt;
  logic [7:0] txb_r [TXB_DEPTH];
  logic [7:0] txb_nxt [TXB_DEPTH];
  logic take;
  logic wr_cmd;
  mrs_cmd_s cmd;
  mrs_stat_s stat;
  logic [15:0] errc_r, errc_nxt;
  logic [7:0] rxb_r [RXB_DEPTH];
  logic [7:0] rx_len_r;
  logic pend_r, bc_r, late_r;
  mrs_tx_e tx_st_r;

  assign take = hsel && htrans[1] && hready;
  assign wr_cmd = ap_wr_r && (ap_addr_r == `MRS_OFS_CMD);
  assign cmd = mrs_cmd_s'(hwdata[23:0]);
  assign stat = '{rx_len: rx_len_r, pad: 4'h0, late: late_r, bcast: bc_r,
                  tx_busy: (tx_st_r == TX_BITS), pending: pend_r};

  always_comb begin
    ap_wr_nxt = take && hwrite;
    ap_addr_nxt = take ? haddr[7:0] : ap_addr_r;
    hrdata_nxt = hrdata_r;
    ctrl_nxt = ctrl_r;
    txb_nxt = txb_r;
    if (take && !hwrite) begin
      hrdata_nxt = 32'h0000_0000;
      case (haddr[7:0])
        `MRS_OFS_CTRL: hrdata_nxt = {16'h0000, ctrl_r};
        `MRS_OFS_STAT: hrdata_nxt = {16'h0000, stat};
        `MRS_OFS_ERRC: hrdata_nxt = {16'h0000, errc_r};
        default: begin
          if (haddr[7:6] == `MRS_WIN_RXB && 32'(haddr[5:2]) < RXB_DEPTH) begin
            hrdata_nxt = {24'h000000, rxb_r[haddr[5:2]]};
          end else if (haddr[7:6] == `MRS_WIN_TXB && 32'(haddr[5:2]) < TXB_DEPTH) begin
            hrdata_nxt = {24'h000000, txb_r[haddr[5:2]]};
          end
        end
      endcase
    end
    if (ap_wr_r && ap_addr_r == `MRS_OFS_CTRL) begin
      ctrl_nxt = mrs_ctrl_s'(hwdata[15:0]);
    end
    // answer bytes are not locked during a send; software waits for tx_busy low
    if (ap_wr_r && ap_addr_r[7:6] == `MRS_WIN_TXB && 32'(ap_addr_r[5:2]) < TXB_DEPTH) begin
      txb_nxt[ap_addr_r[5:2]] = hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      ctrl_r <= mrs_ctrl_s'(`MRS_CTRL_RST);
      for (int i = 0; i < TXB_DEPTH; i++) txb_r[i] <= 8'h00;
    end else begin
      ap_wr_r <= ap_wr_nxt;
      ap_addr_r <= ap_addr_nxt;
      hrdata_r <= hrdata_nxt;
      ctrl_r <= ctrl_nxt;
      txb_r <= txb_nxt;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // line receive, frame judge and answer send
  logic [CW-1:0] div;
  logic [SW-1:0] gap_lim;
  logic par_en, par_odd;
  logic [7:0] station;
  assign div = f_div(ctrl_r.bit_rate_setting);
  assign par_en = ctrl_r.parity_stop_setting != PS_NONE_2STOP;
  assign par_odd = ctrl_r.parity_stop_setting == PS_ODD_1STOP;
  // out of range station numbers fall back to broadcast-only
  assign station = (ctrl_r.station_number_setting > `MRS_STATION_MAX) ? `MRS_ADDR_BCAST :
                   ctrl_r.station_number_setting;
  // rounded up: the gap is a least time
  assign gap_lim = SW'((({7'h00, div} * SW'(`MRS_SIL_HALFBITS)) + SW'(1)) >> 1);

  mrs_rx_e rx_st_r, rx_st_nxt;
  logic [CW-1:0] rx_cnt_r, rx_cnt_nxt;
  logic [3:0] rx_pos_r, rx_pos_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic rx_par_r, rx_par_nxt, rx_prev_r;
  logic [SW-1:0] gap_cnt_r, gap_cnt_nxt;
  logic arm_r, arm_nxt, fr_on_r, fr_on_nxt, fr_bad_r, fr_bad_nxt;
  logic [7:0] rxb_nxt [RXB_DEPTH];
  logic [7:0] rx_len_nxt;
  logic pend_nxt, bc_nxt, late_nxt;
  logic [31:0] rcnt_r, rcnt_nxt, rlim;
  mrs_tx_e tx_st_nxt;
  logic [CW-1:0] tx_cnt_r, tx_cnt_nxt;
  logic [3:0] tx_bit_r, tx_bit_nxt;
  logic [10:0] tx_sh_r, tx_sh_nxt;
  logic [7:0] tx_idx_r, tx_idx_nxt, tx_n_r, tx_n_nxt, nd, tx_byte;
  logic exc_r, exc_nxt;
  logic [7:0] exc_code_r, exc_code_nxt;
  logic oe_r;
  logic gap_done, rx_byte, rx_err, go, crx_init, ctx_init, ctx_en;
  logic [7:0] fc;
  logic [15:0] crc_rx, crc_tx;

  assign gap_done = gap_cnt_r >= gap_lim;
  assign fc = rxb_r[1];
  assign nd = exc_r ? 8'h01 : tx_n_r;

  always_comb begin
    case (ctrl_r.answer_class)
      2'h0: rlim = 32'(FAST_CYC);
      2'h1: rlim = 32'(SLOW_CYC);
      default: rlim = 32'(CLR_CYC);
    endcase
  end

  // byte on the wire for the send index: echo, data, then crc low/high
  always_comb begin
    tx_byte = rxb_r[0];
    if (tx_idx_r == 8'h01) tx_byte = exc_r ? (fc | `MRS_EXC_BIT) : fc;
    else if (tx_idx_r == nd + 8'h02) tx_byte = crc_tx[7:0];
    else if (tx_idx_r == nd + 8'h03) tx_byte = crc_tx[15:8];
    else if (tx_idx_r >= 8'h02) tx_byte = exc_r ? exc_code_r : txb_r[4'(tx_idx_r - 8'h02)];
  end

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_pos_nxt = rx_pos_r;
    rx_sh_nxt = rx_sh_r;
    rx_par_nxt = rx_par_r;
    rx_byte = 1'b0;
    rx_err = 1'b0;
    gap_cnt_nxt = gap_cnt_r;
    arm_nxt = arm_r;
    fr_on_nxt = fr_on_r;
    fr_bad_nxt = fr_bad_r;
    rxb_nxt = rxb_r;
    rx_len_nxt = rx_len_r;
    pend_nxt = pend_r;
    bc_nxt = bc_r;
    late_nxt = late_r;
    rcnt_nxt = rcnt_r;
    errc_nxt = errc_r;
    exc_nxt = exc_r;
    exc_code_nxt = exc_code_r;
    tx_n_nxt = tx_n_r;
    go = 1'b0;
    crx_init = 1'b0;
    // character receiver: mid-bit sampling, one start, eight data bits, parity if enabled, then stop
    case (rx_st_r)
      RX_IDLE: begin
        if (rx_prev_r && !line_in && tx_st_r == TX_IDLE) begin
          rx_st_nxt = RX_BITS;
          rx_cnt_nxt = div >> 1;
          rx_pos_nxt = 4'h0;
          rx_par_nxt = par_odd;
        end
      end
      RX_BITS: begin
        if (rx_cnt_r != '0) begin
          rx_cnt_nxt = rx_cnt_r - CW'(1);
        end else begin
          rx_cnt_nxt = div - CW'(1);
          rx_pos_nxt = rx_pos_r + 4'h1;
          if (rx_pos_r == 4'h0) begin
            if (line_in) rx_st_nxt = RX_IDLE;
          end else if (rx_pos_r <= 4'h8) begin
            rx_sh_nxt = {line_in, rx_sh_r[7:1]};
            rx_par_nxt = rx_par_r ^ line_in;
          end else if (rx_pos_r == 4'h9 && par_en) begin
            rx_par_nxt = rx_par_r ^ line_in;
          end else begin
            rx_st_nxt = RX_IDLE;
            rx_byte = 1'b1;
            rx_err = !line_in || (par_en && rx_par_r);
          end
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    // silence timer restarts on any line activity, including our own send
    if (!line_in || rx_st_r != RX_IDLE || tx_st_r != TX_IDLE) gap_cnt_nxt = '0;
    else if (!gap_done) gap_cnt_nxt = gap_cnt_r + SW'(1);
    if (gap_done) arm_nxt = 1'b1;
    if (rx_byte) begin
      if (!fr_on_r) begin
        crx_init = 1'b1;
        fr_on_nxt = 1'b1;
        arm_nxt = 1'b0;
        // a frame not preceded by a full gap, or arriving while held, is junk
        fr_bad_nxt = !arm_r || pend_r || !ctrl_r.protocol_select_setting || rx_err;
        rx_len_nxt = 8'h00;
      end else if (rx_err) begin
        fr_bad_nxt = 1'b1;
      end
      if (!pend_r) begin
        if ((fr_on_r ? 32'(rx_len_r) : 0) < RXB_DEPTH) begin
          rxb_nxt[fr_on_r ? 4'(rx_len_r) : 4'h0] = rx_sh_r;
        end else begin
          fr_bad_nxt = 1'b1;
        end
        rx_len_nxt = fr_on_r ? ((rx_len_r == 8'hff) ? rx_len_r : rx_len_r + 8'h01) : 8'h01;
      end
    end
    // frame end: a full gap after the last byte
    if (fr_on_r && gap_done) begin
      fr_on_nxt = 1'b0;
      if (pend_r) begin
        fr_on_nxt = 1'b0;
      end else if (fr_bad_r || rx_len_r < `MRS_MIN_LEN || crc_rx != 16'h0000) begin
        errc_nxt = errc_r + 16'h0001;
      end else if (rxb_r[0] != `MRS_ADDR_BCAST && rxb_r[0] != station) begin
        errc_nxt = errc_r;
      end else if (!(fc == `MRS_FC_RD || fc == `MRS_FC_WR1 || fc == `MRS_FC_DIAG ||
                     fc == `MRS_FC_WRN || fc == `MRS_FC_LOG)) begin
        if (rxb_r[0] != `MRS_ADDR_BCAST) begin
          exc_nxt = 1'b1;
          exc_code_nxt = `MRS_EXC_FUNC;
          go = 1'b1;
        end
      end else if (rxb_r[0] == `MRS_ADDR_BCAST && fc != `MRS_FC_WR1 && fc != `MRS_FC_WRN) begin
        errc_nxt = errc_r;
      end else if ((fc == `MRS_FC_RD || fc == `MRS_FC_WR1 || fc == `MRS_FC_WRN) &&
                   {rxb_r[2], rxb_r[3]} > `MRS_REG_MAX) begin
        if (rxb_r[0] != `MRS_ADDR_BCAST) begin
          exc_nxt = 1'b1;
          exc_code_nxt = `MRS_EXC_ADDR;
          go = 1'b1;
        end
      end else begin
        pend_nxt = 1'b1;
        bc_nxt = rxb_r[0] == `MRS_ADDR_BCAST;
        late_nxt = 1'b0;
        rcnt_nxt = 32'h0000_0000;
      end
    end
    // answer deadline watch while software holds the request
    if (pend_r && !bc_r && ctrl_r.answer_class != 2'h3) begin
      if (rcnt_r < rlim) rcnt_nxt = rcnt_r + 32'h0000_0001;
      else late_nxt = 1'b1;
    end
    if (wr_cmd && pend_r && tx_st_r == TX_IDLE) begin
      if (bc_r || cmd.drop || ctrl_r.answer_class == 2'h3) begin
        pend_nxt = cmd.drop || cmd.send || cmd.exc;
        pend_nxt = 1'b0;
      end else if (cmd.exc) begin
        exc_nxt = 1'b1;
        exc_code_nxt = cmd.exc_code;
        go = 1'b1;
      end else if (cmd.send) begin
        exc_nxt = 1'b0;
        tx_n_nxt = (32'(cmd.resp_len) > TXB_DEPTH) ? 8'(TXB_DEPTH) : cmd.resp_len;
        go = 1'b1;
      end
    end
  end

  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt = tx_sh_r;
    tx_idx_nxt = tx_idx_r;
    ctx_init = 1'b0;
    ctx_en = 1'b0;
    case (tx_st_r)
      TX_IDLE: begin
        tx_sh_nxt = 11'h7ff;
        if (go) begin
          tx_st_nxt = TX_BITS;
          tx_idx_nxt = 8'h00;
          tx_bit_nxt = 4'hf;
          tx_cnt_nxt = '0;
        end
      end
      TX_BITS: begin
        if (tx_cnt_r != '0) begin
          tx_cnt_nxt = tx_cnt_r - CW'(1);
        end else begin
          tx_cnt_nxt = div - CW'(1);
          if (tx_bit_r == 4'hf || tx_bit_r == `MRS_CHAR_BITS - 4'h1) begin
            if (tx_bit_r != 4'hf && tx_idx_r == nd + 8'h03) begin
              tx_st_nxt = TX_IDLE;
              tx_sh_nxt = 11'h7ff;
            end else begin
              if (tx_bit_r != 4'hf) tx_idx_nxt = tx_idx_r + 8'h01;
              tx_bit_nxt = 4'h0;
            end
          end else begin
            tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
            tx_bit_nxt = tx_bit_r + 4'h1;
          end
        end
        // load the next character one cycle after the index moves
        if (tx_bit_r == 4'h0 && tx_cnt_r == div - CW'(1)) begin
          tx_sh_nxt = {1'b1, par_en ? (^tx_byte ^ par_odd) : 1'b1, tx_byte, 1'b0};
          ctx_init = tx_idx_r == 8'h00;
          ctx_en = tx_idx_r < nd + 8'h02;
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
  end

  mrs_crc16 u_crc_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .init(crx_init),
    .en(rx_byte),
    .data(rx_sh_r),
    .crc(crc_rx)
  );

  mrs_crc16 u_crc_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .init(ctx_init),
    .en(ctx_en),
    .data(tx_byte),
    .crc(crc_tx)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= '0;
      rx_pos_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
      rx_prev_r <= 1'b1;
      gap_cnt_r <= '0;
      arm_r <= 1'b0;
      fr_on_r <= 1'b0;
      fr_bad_r <= 1'b0;
      for (int i = 0; i < RXB_DEPTH; i++) rxb_r[i] <= 8'h00;
      rx_len_r <= 8'h00;
      pend_r <= 1'b0;
      bc_r <= 1'b0;
      late_r <= 1'b0;
      rcnt_r <= 32'h0000_0000;
      errc_r <= 16'h0000;
      exc_r <= 1'b0;
      exc_code_r <= 8'h00;
      tx_n_r <= 8'h00;
      tx_st_r <= TX_IDLE;
      tx_cnt_r <= '0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 11'h7ff;
      tx_idx_r <= 8'h00;
      oe_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_pos_r <= rx_pos_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_par_r <= rx_par_nxt;
      rx_prev_r <= line_in;
      gap_cnt_r <= gap_cnt_nxt;
      arm_r <= arm_nxt;
      fr_on_r <= fr_on_nxt;
      fr_bad_r <= fr_bad_nxt;
      rxb_r <= rxb_nxt;
      rx_len_r <= rx_len_nxt;
      pend_r <= (tx_st_r == TX_BITS && tx_st_nxt == TX_IDLE) ? 1'b0 : pend_nxt;
      bc_r <= bc_nxt;
      late_r <= late_nxt;
      rcnt_r <= rcnt_nxt;
      errc_r <= errc_nxt;
      exc_r <= exc_nxt;
      exc_code_r <= exc_code_nxt;
      tx_n_r <= tx_n_nxt;
      tx_st_r <= tx_st_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_idx_r <= tx_idx_nxt;
      oe_r <= tx_st_nxt == TX_BITS;
    end
  end

  assign line_out = tx_sh_r[0];
  assign line_oe = oe_r;

endmodule : mrs_framer

/* File: mrs_framer_monitor.sv */
// Purpose: bus and line checks for the rtu slave framer
// Assumes: one slave, hready fed back from hreadyout
// Notes: bound to every mrs_framer
`timescale 1ns/1ps
module mrs_framer_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic line_in,
  input wire logic line_out,
  input wire logic line_oe
);
  logic take;
  logic wr_ctrl_r;
  logic wr_ctrl_nxt;
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  assign take = hsel && htrans[1] && hready;
  // shadow of ctrl, updated in the write data phase
  always_comb begin
    wr_ctrl_nxt = take && hwrite && haddr[7:0] == 8'h00;
    ctrl_nxt = wr_ctrl_r ? hwdata[15:0] : ctrl_r;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl_r <= 1'b0;
      ctrl_r <= 16'h1500;
    end else begin
      wr_ctrl_r <= wr_ctrl_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence rd_at(logic [7:0] a);
    take && !hwrite && haddr[7:0] == a;
  endsequence
  sequence drive_held;
    line_oe [*8];
  endsequence
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_zero_wait: assert property (hreadyout)
    else $error("wait state seen");
  chk_rdata_hold: assert property (!$past(take && !hwrite) |-> $stable(hrdata))
    else $error("read data moved without a read");
  chk_ctrl_back: assert property (rd_at(8'h00) |=> hrdata[15:0] == $past(ctrl_r))
    else $error("settings read back wrong");
  chk_cmd_reads_zero: assert property (rd_at(8'h08) |=> hrdata == 32'h0)
    else $error("command word read nonzero");
  chk_hole_zero: assert property (rd_at(8'h30) |=> hrdata == 32'h0)
    else $error("unmapped read nonzero");
  chk_drive_hold: assert property ($rose(line_oe) |-> drive_held)
    else $error("driver enable pulse too short");
  chk_release_high: assert property ($fell(line_oe) |-> $past(line_out))
    else $error("line released before stop bit");
endmodule : mrs_framer_monitor
bind mrs_framer mrs_framer_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .line_in(line_in), .line_out(line_out), .line_oe(line_oe));

/* File: mrs_master_model.sv */
// Purpose: bus master at the far end of the rtu line
// Assumes: even parity, one stop, DIV clocks per bit
// Notes: line is biased high, so released means idle 1
`timescale 1ns/1ps
module mrs_master_model #(
  parameter int DIV = 8
) (
  input wire logic hclk,
  input wire logic line_out,
  input wire logic line_oe,
  output logic line_in
);
  logic [7:0] rxq[$];
  logic [7:0] b;
  int i;
  initial line_in = 1'b1;
  ////////////////////////////////////////
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[k]) begin
      c = c ^ {8'h00, q[k]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc16
  task automatic send(input logic [7:0] q[$], input bit bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    // silence runs from the end of the answer on the line, not its last sampled bit
    for (int n = 0; n < 4000 && line_oe !== 1'b0; n++) @(posedge hclk);
    repeat (40 * DIV) @(posedge hclk);
    foreach (q[k]) begin
      for (int n = 0; n < 11; n++) begin
        line_in <= 1'({1'b1, ^q[k], q[k], 1'b0} >> n);
        repeat (DIV) @(posedge hclk);
      end
    end
  endtask : send
  // start seen up to a cycle late, so sample near mid bit
  initial forever begin
    @(posedge hclk);
    if (line_oe === 1'b1 && line_out === 1'b0) begin
      repeat (DIV / 2) @(posedge hclk);
      for (i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge hclk);
        b[i] = line_out;
      end
      rxq.push_back(b);
      repeat (2 * DIV) @(posedge hclk);
    end
  end
endmodule : mrs_master_model

/* File: modbus_rtu_slave_framer_tb_top.sv */
// Purpose: self-checking bench for the rtu slave framer
// Assumes: 38400 bps at eight clocks per bit, station 5
// Notes: deadlines scaled down to keep runs short
`timescale 1ns/1ps
module modbus_rtu_slave_framer_tb_top;
  import mrs_pkg::*;
  localparam int DIV = 8;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, line_in, line_out, line_oe;
  logic [31:0] haddr, hwdata, hrdata, rd, e;
  logic [1:0] htrans;
  logic [7:0] exp_q[$];
  logic [7:0] fc[5] = '{8'h03, 8'h06, 8'h08, 8'h10, 8'h46};
  mrs_stat_s st;
  int miscompares = 0;
  int samples_checked = 0;
  mrs_framer #(.CLK_HZ(DIV * 38400), .FAST_CYC(200), .SLOW_CYC(400), .CLR_CYC(800)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .line_in(line_in), .line_out(line_out),
    .line_oe(line_oe));
  mrs_master_model #(.DIV(DIV)) M (.hclk(hclk), .line_out(line_out), .line_oe(line_oe),
    .line_in(line_in));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict(input bit hung);
    if (hung) miscompares++;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic wait_rdy;
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      if (++n > 50) give_verdict(1);
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic wait_pend;
    for (int n = 0; n < 300; n++) begin
      bus(0, 8'h04, 0);
      if (rd[0] === 1'b1) return;
      repeat (8) @(posedge hclk);
    end
    give_verdict(1);
  endtask : wait_pend
  task automatic q6(input logic [7:0] a, input logic [7:0] f, input bit bad);
    M.send('{a, f, 8'h00, 8'h00, 8'h00, 8'h01}, bad);
  endtask : q6
  task automatic exp_frame(input logic [7:0] q[$]);
    logic [15:0] c;
    c = M.crc16(q);
    exp_q = q;
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
  endtask : exp_frame
  // empty exp_q means silence is expected for the whole window
  task automatic expect_answer;
    for (int n = 0; n < 3000 && M.rxq.size() < exp_q.size(); n++) @(posedge hclk);
    if (M.rxq.size() < exp_q.size()) give_verdict(1);
    if (exp_q.size() == 0) repeat (3000) @(posedge hclk);
    check(M.rxq.size(), exp_q.size());
    foreach (exp_q[k]) check(M.rxq[k], exp_q[k]);
    M.rxq.delete();
    exp_q.delete();
  endtask : expect_answer
  ////////////////////////////////////////
  task automatic s_setup;
    check(hrdata, 32'h0);
    check(line_oe, 1'b0);
    bus(0, 8'h00, 0);
    check(rd, 32'h1500);
    bus(0, 8'h30, 0);
    check(rd, 32'h0);
    bus(0, 8'h08, 0);
    check(rd, 32'h0);
    bus(1, 8'h00, 32'h9705);
    bus(0, 8'h00, 0);
    check(rd, 32'h9705);
  endtask : s_setup
  task automatic s_codes;
    foreach (fc[i]) begin
      q6(8'h05, fc[i], 0);
      wait_pend();
      bus(0, 8'h44, 0);
      check(rd, fc[i]);
      bus(1, 8'h08, 32'h4);
    end
  endtask : s_codes
  task automatic s_normal;
    q6(8'h05, 8'h03, 0);
    wait_pend();
    st = mrs_stat_s'(rd[15:0]);
    check(st.rx_len, 8'h08);
    check(st.late, 1'b0);
    bus(1, 8'h80, 32'h2);
    bus(1, 8'h84, 32'h0);
    bus(1, 8'h88, 32'h2a);
    repeat (200) @(posedge hclk);
    bus(0, 8'h04, 0);
    check(rd[3], 1'b1);
    exp_frame('{8'h05, 8'h03, 8'h02, 8'h00, 8'h2a});
    bus(1, 8'h08, 32'h0301);
    expect_answer();
  endtask : s_normal
  task automatic s_errors;
    q6(8'h05, 8'h41, 0);
    exp_frame('{8'h05, 8'hc1, 8'h01});
    expect_answer();
    M.send('{8'h05, 8'h03, 8'h27, 8'h0f, 8'h00, 8'h01}, 0);
    exp_frame('{8'h05, 8'h83, 8'h02});
    expect_answer();
    q6(8'h05, 8'h06, 0);
    wait_pend();
    exp_frame('{8'h05, 8'h86, 8'h03});
    bus(1, 8'h08, 32'h00030002);
    expect_answer();
  endtask : s_errors
  task automatic s_silent;
    bus(0, 8'h0c, 0);
    e = rd;
    q6(8'h05, 8'h03, 1);
    expect_answer();
    bus(0, 8'h0c, 0);
    check(rd, e + 1);
    q6(8'h06, 8'h03, 0);
    expect_answer();
    q6(8'h00, 8'h03, 0);
    expect_answer();
    bus(1, 8'h08, 32'h4);
    q6(8'h00, 8'h06, 0);
    wait_pend();
    st = mrs_stat_s'(rd[15:0]);
    check(st.bcast, 1'b1);
    bus(1, 8'h08, 32'h0201);
    expect_answer();
    bus(0, 8'h04, 0);
    check(rd[0], 1'b0);
  endtask : s_silent
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    s_setup();
    s_codes();
    s_normal();
    s_errors();
    s_silent();
    give_verdict(0);
  end
endmodule : modbus_rtu_slave_framer_tb_top
